/* rtl/ast_pkg.sv */
// constants, field layouts and state types of the asynchronous serial transceiver
package ast_pkg;
  localparam int          ADDR_W       = 5;
  localparam logic [4:0]  OFS_MODE     = 5'h00;
  localparam logic [4:0]  OFS_STA      = 5'h04;
  localparam logic [4:0]  OFS_TX       = 5'h08;
  localparam logic [4:0]  OFS_RX       = 5'h0c;
  localparam logic [4:0]  OFS_BAUD     = 5'h10;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  // mode register fields
  localparam int          MD_EN        = 15;
  localparam int          MD_SIMPLEX   = 11;
  localparam int          MD_PIN       = 8;
  localparam int          MD_LOOP      = 6;
  localparam int          MD_HSPEED    = 3;
  localparam int          MD_FMT       = 1;
  localparam int          MD_STOP2     = 0;
  localparam logic [15:0] MODE_WMASK   = 16'h8b4f;
  localparam logic [15:0] MODE_RESET   = 16'h0000;
  // status and control register fields
  localparam int          ST_TXSEL1    = 15;
  localparam int          ST_TXSEL0    = 13;
  localparam int          ST_BRK       = 11;
  localparam int          ST_TXEN      = 10;
  localparam int          ST_TXFULL    = 9;
  localparam int          ST_TRMT      = 8;
  localparam int          ST_RXSEL     = 6;
  localparam int          ST_ADDEN     = 5;
  localparam int          ST_RIDLE     = 4;
  localparam int          ST_PARITY_ERROR_FLAG      = 3;
  localparam int          ST_FRAMING_ERROR_FLAG      = 2;
  localparam int          ST_OVERRUN_FLAG      = 1;
  localparam int          ST_RXDA      = 0;
  localparam logic [15:0] STA_WMASK    = 16'hace0;
  localparam logic [15:0] STA_RESET    = 16'h0000;
  localparam logic [15:0] BAUD_RESET   = 16'h0000;
  // encodings
  localparam logic [1:0]  FMT_8N       = 2'h0;
  localparam logic [1:0]  FMT_8E       = 2'h1;
  localparam logic [1:0]  FMT_8O       = 2'h2;
  localparam logic [1:0]  FMT_9N       = 2'h3;
  localparam logic [1:0]  PIN_RTS      = 2'h1;
  localparam logic [1:0]  PIN_CTS_RTS  = 2'h2;
  localparam logic [1:0]  PIN_BCLK     = 2'h3;
  localparam logic [1:0]  TXI_DONE     = 2'h1;
  localparam logic [1:0]  TXI_EMPTY    = 2'h2;
  localparam logic [1:0]  RXI_THREE    = 2'h2;
  localparam logic [1:0]  RXI_FULL     = 2'h3;
  // timing and sizes
  localparam logic [4:0]  SPB_STD      = 5'h10;
  localparam logic [4:0]  SPB_HS       = 5'h04;
  localparam logic [3:0]  BRK_ZEROS    = 4'hc;
  localparam int          FIFO_DEPTH   = 4;
  localparam int          CNT_W        = 3;
  localparam int          TX_W         = 9;
  localparam int          RX_W         = 11;
  localparam int          SH_W         = 15;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b01,
    TX_SHIFT = 2'b10
  } ast_tx_state_type;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_START = 3'b010,
    RX_DATA  = 3'b100
  } ast_rx_state_type;
endpackage : ast_pkg

/* rtl/ast_fifo.sv */
// small first-in first-out queue held in flip-flops
`timescale 1ns/10ps
module ast_fifo
  import ast_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             clr,
  input  wire logic             push,
  input  wire logic [W-1:0]     push_data,
  input  wire logic             pop,
  output logic      [W-1:0]     head,
  output logic      [CNT_W-1:0] count,
  output logic                  full,
  output logic                  empty
);
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(FIFO_DEPTH);
  localparam logic [1:0]       ONE_PTR = 2'h1;

  logic [W-1:0]     mem_q [FIFO_DEPTH];
  logic [W-1:0]     mem_d [FIFO_DEPTH];
  logic [1:0]       wr_q, wr_d, rd_q, rd_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             do_push, do_pop;

  assign do_pop  = pop && (cnt_q != '0);
  assign do_push = push && (cnt_q != DEPTH_C);
  assign head    = mem_q[rd_q];
  assign count   = cnt_q;
  assign full    = (cnt_q == DEPTH_C);
  assign empty   = (cnt_q == '0);

  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (clr) begin
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end else begin
      if (do_push) begin
        mem_d[wr_q] = push_data;
        wr_d        = wr_q + ONE_PTR;
      end
      if (do_pop) begin
        rd_d = rd_q + ONE_PTR;
      end
      cnt_d = cnt_q + CNT_W'(do_push) - CNT_W'(do_pop);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule : ast_fifo

/* rtl/ast_top.sv */
// asynchronous serial transceiver with baud timer, queues and register slave
// Behaviour
// - free-running 16-bit baud timer, period set by the baud divisor
// - standard speed: bit rate is clock over 16 times (divisor plus one)
// - high speed: bit rate is clock over 4 times (divisor plus one)
// - writing the baud divisor clears the baud timer at once
// - setting transmit enable raises a transmit interrupt two cycles later
// - 8-bit byte written passes through the transmit queue to the shifter and starts shifting
// - character loaded while disabled starts at once when transmit is enabled
// - with send break set, the next character is ignored and a break sent
// - after the break, send break self-clears and the next character follows
// - four-entry queue ahead of the transmit shifter
// - four-entry queue for received characters
// - reading receive holding advances the queue with its own error flags
// - overrun flag stays set until software clears it
// - receive interrupt per selected fill level once characters arrive
// - 8-bit even, odd or no parity, generated and checked
// - one or two stop bits as configured
// - 9-bit address detect treats ninth bit one as an address character
// - parity errors, framing errors and overruns are flagged
// - loopback returns transmitted data to the receiver
// - baud clock output only with 16x oversampling selected
// - pin usage 11 with module enabled drives 16x baud clock on shared pin
// - break is a start bit, twelve zero bits and a stop bit
// - format 11 9-bit, 10 8-bit odd, 01 8-bit even, 00 8-bit none
// - clear-to-send and request-to-send serve simplex or flow control
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
module ast_top
  import ast_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              serial_in_pin,
  output logic                   serial_out_pin,
  output logic                   serial_out_oe,
  input  wire logic              clear_to_send_pin_n,
  output logic                   rts_bclk_pin,
  output logic                   rts_bclk_oe,
  output logic                   tx_irq,
  output logic                   rx_irq
);
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (strb[0]) v[7:0] = nw[7:0];
    if (strb[1]) v[15:8] = nw[15:8];
    return (v & mask) | (old & ~mask);
  endfunction : merge16

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    return (a == OFS_MODE) || (a == OFS_STA) || (a == OFS_TX) || (a == OFS_RX) ||
           (a == OFS_BAUD);
  endfunction : addr_hit

  // register and bus state
  logic [15:0]       mode_q, mode_d, sta_q, sta_d, baud_q, baud_d;
  logic              overrun_flag_q, overrun_flag_d;
  logic              awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic              arready_q, arready_d, rvalid_q, rvalid_d;
  logic              aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic [31:0]       w_data_q, w_data_d, rdata_q, rdata_d;
  logic [3:0]        w_strb_q, w_strb_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
  // baud and pins
  logic [15:0]       brg_q, brg_d;
  logic              bclk_q, bclk_d, rts_q, rts_d, pin_oe_q, pin_oe_d;
  logic [2:0]        rxs_q, ctss_q;
  logic              rx_lvl_q, rx_lvl_d, cts_lvl_q, cts_lvl_d;
  // transmitter
  ast_tx_state_type  tx_st_q, tx_st_d;
  logic [SH_W-1:0]   tx_sh_q, tx_sh_d;
  logic [3:0]        tx_left_q, tx_left_d;
  logic [4:0]        tx_sub_q, tx_sub_d;
  logic              tx_brk_q, tx_brk_d;
  logic [1:0]        txen_dly_q, txen_dly_d;
  logic              tx_irq_q, tx_irq_d;
  // receiver
  ast_rx_state_type  rx_st_q, rx_st_d;
  logic [9:0]        rx_sh_q, rx_sh_d;
  logic [3:0]        rx_bit_q, rx_bit_d;
  logic [4:0]        rx_sub_q, rx_sub_d;
  logic              rx_irq_q, rx_irq_d;
  // combinational helpers
  logic              en, txen, hspeed, fmt9, tick, do_write, wr_baud, brk_clr;
  logic [1:0]        fmt, pins;
  logic [4:0]        spb;
  logic              txf_push, txf_pop, txf_full, txf_empty, tx_start, tx_done;
  logic [TX_W-1:0]   txf_head;
  logic [CNT_W-1:0]  txf_cnt, rxf_cnt;
  logic              rxf_push, rxf_pop, rxf_full, rxf_empty, rxf_clr, rx_in;
  logic [RX_W-1:0]   rxf_head, rxf_data;
  logic [3:0]        rx_stop_idx;

  assign en     = mode_q[MD_EN];
  assign txen   = sta_q[ST_TXEN];
  assign hspeed = mode_q[MD_HSPEED];
  assign fmt    = mode_q[MD_FMT +: 2];
  assign fmt9   = (fmt == FMT_9N);
  assign pins   = mode_q[MD_PIN +: 2];
  assign spb    = hspeed ? SPB_HS : SPB_STD;
  assign tick   = (brg_q == baud_q);

  assign s_axi_awready  = awready_q;
  assign s_axi_wready   = wready_q;
  assign s_axi_bvalid   = bvalid_q;
  assign s_axi_bresp    = bresp_q;
  assign s_axi_arready  = arready_q;
  assign s_axi_rvalid   = rvalid_q;
  assign s_axi_rdata    = rdata_q;
  assign s_axi_rresp    = rresp_q;
  assign serial_out_pin = tx_sh_q[0];
  assign serial_out_oe  = en;
  assign rts_bclk_pin   = rts_q;
  assign rts_bclk_oe    = pin_oe_q;
  assign tx_irq         = tx_irq_q;
  assign rx_irq         = rx_irq_q;

  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign wr_baud  = do_write && (aw_addr_q == OFS_BAUD) && (w_strb_q[1:0] != '0);
  assign txf_push = do_write && (aw_addr_q == OFS_TX) && w_strb_q[0];
  assign rxf_pop  = s_axi_arvalid && arready_q && (s_axi_araddr == OFS_RX);
  // clearing a set overrun flag empties the receive queue
  assign rxf_clr  = overrun_flag_q && !overrun_flag_d;

  ast_fifo #(.W(TX_W)) u_tx_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .clr       (1'b0),
    .push      (txf_push),
    .push_data (w_data_q[TX_W-1:0]),
    .pop       (txf_pop),
    .head      (txf_head),
    .count     (txf_cnt),
    .full      (txf_full),
    .empty     (txf_empty)
  );

  ast_fifo #(.W(RX_W)) u_rx_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .clr       (rxf_clr),
    .push      (rxf_push),
    .push_data (rxf_data),
    .pop       (rxf_pop),
    .head      (rxf_head),
    .count     (rxf_cnt),
    .full      (rxf_full),
    .empty     (rxf_empty)
  );

  // register file and bus slave
  always_comb begin
    mode_d    = mode_q;
    sta_d     = sta_q;
    baud_d    = baud_q;
    overrun_flag_d    = overrun_flag_q;
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    aw_addr_d = aw_addr_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    arready_d = arready_q;
    if (s_axi_awvalid && awready_q) begin
      aw_full_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_full_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (brk_clr) sta_d[ST_BRK] = 1'b0;
    if (do_write) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = addr_hit(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      case (aw_addr_q)
        OFS_MODE: mode_d = merge16(mode_q, w_data_q, w_strb_q, MODE_WMASK);
        OFS_STA: begin
          sta_d = merge16(sta_q, w_data_q, w_strb_q, STA_WMASK);
          if (w_strb_q[0] && !w_data_q[ST_OVERRUN_FLAG]) overrun_flag_d = 1'b0;
        end
        OFS_BAUD: baud_d = merge16(baud_q, w_data_q, w_strb_q, 16'hffff);
        default: ;
      endcase
    end
    if (rxf_push && rxf_full) overrun_flag_d = 1'b1;
    if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFS_MODE: rdata_d = {16'h0000, mode_q};
        OFS_STA: begin
          rdata_d            = {16'h0000, sta_q};
          rdata_d[ST_TXFULL] = txf_full;
          rdata_d[ST_TRMT]   = txf_empty && (tx_st_q == TX_IDLE);
          rdata_d[ST_RIDLE]  = (rx_st_q == RX_IDLE);
          rdata_d[ST_PARITY_ERROR_FLAG]   = !rxf_empty && rxf_head[TX_W];
          rdata_d[ST_FRAMING_ERROR_FLAG]   = !rxf_empty && rxf_head[TX_W+1];
          rdata_d[ST_OVERRUN_FLAG]   = overrun_flag_q;
          rdata_d[ST_RXDA]   = !rxf_empty;
        end
        OFS_RX: rdata_d = {23'h000000, rxf_head[TX_W-1:0]};
        OFS_BAUD: rdata_d = {16'h0000, baud_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
    awready_d = !aw_full_d && !bvalid_d;
    wready_d  = !w_full_d && !bvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q    <= MODE_RESET;
      sta_q     <= STA_RESET;
      baud_q    <= BAUD_RESET;
      overrun_flag_q    <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else begin
      mode_q    <= mode_d;
      sta_q     <= sta_d;
      baud_q    <= baud_d;
      overrun_flag_q    <= overrun_flag_d;
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      aw_addr_q <= aw_addr_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // baud timer, pin synchronisers, shared-pin drive
  always_comb begin
    brg_d = tick ? 16'h0000 : brg_q + 16'h0001;
    if (!en || wr_baud || (txen && !txen_dly_q[0])) brg_d = 16'h0000;
    bclk_d    = en && !hspeed && (brg_q <= (baud_q >> 1));
    rx_lvl_d  = (rxs_q[1] == rxs_q[2]) ? rxs_q[2] : rx_lvl_q;
    cts_lvl_d = (ctss_q[1] == ctss_q[2]) ? ctss_q[2] : cts_lvl_q;
    // flow control: ready to receive; simplex: transmitter busy
    rts_d = mode_q[MD_SIMPLEX] ? !(tx_st_q == TX_SHIFT || !txf_empty)
                               : rxf_full;
    if (pins == PIN_BCLK) rts_d = bclk_q;
    pin_oe_d = en && (pins != '0);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brg_q     <= 16'h0000;
      bclk_q    <= 1'b0;
      rts_q     <= 1'b1;
      pin_oe_q  <= 1'b0;
      rxs_q     <= 3'h7;
      ctss_q    <= 3'h7;
      rx_lvl_q  <= 1'b1;
      cts_lvl_q <= 1'b1;
    end else begin
      brg_q     <= brg_d;
      bclk_q    <= bclk_d;
      rts_q     <= rts_d;
      pin_oe_q  <= pin_oe_d;
      rxs_q     <= {rxs_q[1:0], serial_in_pin};
      ctss_q    <= {ctss_q[1:0], clear_to_send_pin_n};
      rx_lvl_q  <= rx_lvl_d;
      cts_lvl_q <= cts_lvl_d;
    end
  end

  // transmitter
  assign tx_start = (tx_st_q == TX_IDLE) && en && txen && !txf_empty &&
                    ((pins != PIN_CTS_RTS) || !cts_lvl_q);
  assign txf_pop  = tx_start;
  assign tx_done  = (tx_st_q == TX_SHIFT) && tick && (tx_sub_q == spb - 5'h01) &&
                    (tx_left_q == 4'h1);
  assign brk_clr  = tx_done && tx_brk_q;

  always_comb begin
    tx_st_d    = tx_st_q;
    tx_sh_d    = tx_sh_q;
    tx_left_d  = tx_left_q;
    tx_sub_d   = tx_sub_q;
    tx_brk_d   = tx_brk_q;
    txen_dly_d = {txen_dly_q[0], txen};
    tx_irq_d   = txen_dly_q[0] && !txen_dly_q[1];
    case (tx_st_q)
      TX_IDLE: begin
        if (tx_start) begin
          tx_st_d  = TX_SHIFT;
          tx_sub_d = 5'h00;
          tx_sh_d  = '1;
          tx_brk_d = sta_q[ST_BRK];
          if (sta_q[ST_BRK]) begin
            tx_sh_d[BRK_ZEROS:0] = '0;
            tx_left_d            = BRK_ZEROS + 4'h2 + 4'(mode_q[MD_STOP2]);
          end else begin
            tx_sh_d[0]   = 1'b0;
            tx_sh_d[8:1] = txf_head[7:0];
            if (fmt9) tx_sh_d[9] = txf_head[8];
            else if (fmt == FMT_8E) tx_sh_d[9] = ^txf_head[7:0];
            else if (fmt == FMT_8O) tx_sh_d[9] = ~^txf_head[7:0];
            tx_left_d = 4'h9 + 4'(fmt != FMT_8N) + 4'h1 + 4'(mode_q[MD_STOP2]);
          end
          tx_irq_d = tx_irq_d || (sta_q[ST_TXSEL1] ? (txf_cnt == CNT_W'(1)) :
                                  !sta_q[ST_TXSEL0]);
        end
      end
      TX_SHIFT: begin
        if (tick) begin
          tx_sub_d = tx_sub_q + 5'h01;
          if (tx_sub_q == spb - 5'h01) begin
            tx_sub_d  = 5'h00;
            tx_sh_d   = {1'b1, tx_sh_q[SH_W-1:1]};
            tx_left_d = tx_left_q - 4'h1;
            if (tx_left_q == 4'h1) tx_st_d = TX_IDLE;
          end
        end
        if (tx_done && txf_empty && ({sta_q[ST_TXSEL1], sta_q[ST_TXSEL0]} == TXI_DONE)) begin
          tx_irq_d = 1'b1;
        end
      end
      default: tx_st_d = TX_IDLE;
    endcase
    if (!en || !txen) begin
      tx_st_d = TX_IDLE;
      tx_sh_d = '1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_q    <= TX_IDLE;
      tx_sh_q    <= '1;
      tx_left_q  <= 4'h0;
      tx_sub_q   <= 5'h00;
      tx_brk_q   <= 1'b0;
      txen_dly_q <= 2'h0;
      tx_irq_q   <= 1'b0;
    end else begin
      tx_st_q    <= tx_st_d;
      tx_sh_q    <= tx_sh_d;
      tx_left_q  <= tx_left_d;
      tx_sub_q   <= tx_sub_d;
      tx_brk_q   <= tx_brk_d;
      txen_dly_q <= txen_dly_d;
      tx_irq_q   <= tx_irq_d;
    end
  end

  // receiver
  assign rx_in       = mode_q[MD_LOOP] ? tx_sh_q[0] : rx_lvl_q;
  assign rx_stop_idx = (fmt == FMT_8N) ? 4'h8 : 4'h9;
  assign rxf_data[TX_W-1:0] = fmt9 ? rx_sh_q[8:0] : {1'b0, rx_sh_q[7:0]};
  assign rxf_data[TX_W]     = (fmt == FMT_8E) ? ^rx_sh_q[8:0] :
                              (fmt == FMT_8O) ? ~^rx_sh_q[8:0] : 1'b0;
  assign rxf_data[TX_W+1]   = !rx_in;
  assign rxf_push = en && (rx_st_q == RX_DATA) && tick && (rx_sub_q == spb - 5'h01) &&
                    (rx_bit_q == rx_stop_idx) &&
                    !(fmt9 && sta_q[ST_ADDEN] && !rx_sh_q[8]);

  always_comb begin
    rx_st_d  = rx_st_q;
    rx_sh_d  = rx_sh_q;
    rx_bit_d = rx_bit_q;
    rx_sub_d = rx_sub_q;
    rx_irq_d = 1'b0;
    case (rx_st_q)
      RX_IDLE: begin
        rx_sub_d = 5'h00;
        if (!rx_in) rx_st_d = RX_START;
      end
      RX_START: begin
        if (tick) begin
          rx_sub_d = rx_sub_q + 5'h01;
          if (rx_sub_q == (spb >> 1) - 5'h01) begin
            rx_sub_d = 5'h00;
            rx_bit_d = 4'h0;
            rx_sh_d  = '0;
            rx_st_d  = rx_in ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          rx_sub_d = rx_sub_q + 5'h01;
          if (rx_sub_q == spb - 5'h01) begin
            rx_sub_d = 5'h00;
            rx_bit_d = rx_bit_q + 4'h1;
            if (rx_bit_q == rx_stop_idx) rx_st_d = RX_IDLE;
            else rx_sh_d[rx_bit_q] = rx_in;
          end
        end
      end
      default: rx_st_d = RX_IDLE;
    endcase
    if (rxf_push && !rxf_full) begin
      case (sta_q[ST_RXSEL +: 2])
        RXI_THREE: rx_irq_d = (rxf_cnt == CNT_W'(2));
        RXI_FULL:  rx_irq_d = (rxf_cnt == CNT_W'(3));
        default:   rx_irq_d = 1'b1;
      endcase
    end
    if (!en) rx_st_d = RX_IDLE;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_q  <= RX_IDLE;
      rx_sh_q  <= '0;
      rx_bit_q <= 4'h0;
      rx_sub_q <= 5'h00;
      rx_irq_q <= 1'b0;
    end else begin
      rx_st_q  <= rx_st_d;
      rx_sh_q  <= rx_sh_d;
      rx_bit_q <= rx_bit_d;
      rx_sub_q <= rx_sub_d;
      rx_irq_q <= rx_irq_d;
    end
  end
endmodule : ast_top

/* test/ast_checker.sv */
// bus handshake and line checks on the transceiver ports
`timescale 1ns/10ps
module ast_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_out_oe,
  input wire logic rx_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped early");
  a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("awready while response pending");
  a_aw_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not freed");
  a_rx_pulse: assert property (rx_irq |=> !rx_irq) else $error("rx irq not a pulse");
  a_oe_reset: assert property ($rose(aresetn) |-> !serial_out_oe)
    else $error("line driven after reset");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (rx_irq);
endmodule : ast_checker
bind ast_top ast_checker i_chk (.*);

/* test/ast_peer.sv */
// remote serial peer: sends and collects 8-bit frames
`timescale 1ns/10ps
module ast_peer #(parameter int BT = 32) (
  input wire logic aclk, line_in, output logic line_out);
  logic [7:0] got[$];
  initial line_out = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (BT) @(posedge aclk);
    end
  endtask : send
  always begin : rx
    logic [7:0] v;
    do @(posedge aclk); while (line_in !== 1'b1);
    do @(posedge aclk); while (line_in !== 1'b0);
    repeat (BT / 2) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BT) @(posedge aclk);
      v[i] = line_in;
    end
    repeat (BT) @(posedge aclk);
    got.push_back(v);
  end
endmodule : ast_peer

/* test/ast_top_tb.sv */
// bench for the serial transceiver: registers, transmit, break and receive
`timescale 1ns/10ps
module ast_top_tb;
  import ast_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, serial_in_pin, serial_out_pin, serial_out_oe;
  logic clear_to_send_pin_n = 0, rts_bclk_pin, rts_bclk_oe, tx_irq, rx_irq;
  logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int err_total = 0, n_tests = 0, n_txi = 0, n_rxi = 0, nb = 0;
  logic [7:0] exp_q[$];
  ast_top i_dut (.*);
  ast_peer #(.BT(32)) i_peer (.aclk, .line_in(serial_out_pin), .line_out(serial_in_pin));
  always #12.5 aclk = ~aclk;
  // interrupt pulses counted for the model
  always @(posedge aclk) begin
    if (tx_irq === 1'b1) n_txi++;
    if (rx_irq === 1'b1) n_rxi++;
  end
  task automatic chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] r);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_bready <= 1;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    chk(s_axi_bresp, r);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] r);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, r);
  endtask : rd
  task automatic drain(input int n);
    for (int k = 0; k < 3000 && i_peer.got.size() < n; k++) @(posedge aclk);
    chk(i_peer.got.size(), n);
    while (exp_q.size()) chk(i_peer.got.pop_front(), exp_q.pop_front());
  endtask : drain
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    #2000000;
    err_total++;
    summarize();
  end
  initial begin
    void'($urandom(32'h45672fdc));
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(OFS_MODE, {16'h0, MODE_RESET}, RESP_OKAY);
    rd(OFS_STA, {16'h0, STA_RESET} | 32'h0110, RESP_OKAY);
    rd(5'h14, 32'h0, RESP_SLVERR);
    wr(5'h14, 32'hffff, RESP_SLVERR);
    wr(OFS_BAUD, 32'h1, RESP_OKAY);
    wr(OFS_MODE, 32'h8000, RESP_OKAY);
    wr(OFS_STA, 32'h0400, RESP_OKAY);
    $display("test registers done");
    repeat (3) begin
      d = $urandom;
      exp_q.push_back(d[7:0]);
      wr(OFS_TX, {24'h0, d[7:0]}, RESP_OKAY);
    end
    drain(3);
    chk(n_txi, 4);
    $display("test transmit done");
    exp_q = '{8'h00, 8'h55};
    wr(OFS_STA, 32'h0c00, RESP_OKAY);
    wr(OFS_TX, 32'h00a5, RESP_OKAY);
    wr(OFS_TX, 32'h0055, RESP_OKAY);
    drain(2);
    $display("test break done");
    repeat (2) begin
      d = $urandom;
      exp_q.push_back(d[7:0]);
      i_peer.send(d[7:0]);
    end
    repeat (4) @(posedge aclk);
    repeat (2) rd(OFS_RX, {24'h0, exp_q.pop_front()}, RESP_OKAY);
    rd(OFS_STA, 32'h0510, RESP_OKAY);
    chk(n_rxi, 2);
    $display("test receive done");
    wr(OFS_MODE, 32'h8342, RESP_OKAY);
    d = $urandom;
    wr(OFS_TX, {24'h0, d[7:0]}, RESP_OKAY);
    repeat (32) @(posedge aclk) nb += rts_bclk_pin;
    chk(nb, 16);
    chk({rts_bclk_oe, serial_out_oe}, 2'b11);
    repeat (400) @(posedge aclk);
    rd(OFS_STA, 32'h0511, RESP_OKAY);
    rd(OFS_RX, {24'h0, d[7:0]}, RESP_OKAY);
    $display("test loopback done");
    summarize();
  end
endmodule : ast_top_tb
